// file: rtl/frsc_top.sv
// fan drive rate, ramp span and over-temperature pin configuration
//
// Behaviour
// - three channel registers pair remote1/out1, local/out2, remote2/out3
// - bits 2:0 pick drive frequency, 11.0 to 88.2 Hz over eight codes
// - rate field resets to code 100, 35.3 Hz
// - bit 3 set: pull over-temperature pin low when channel exceeds its limit
// - pin stays low until temperature is at or below the limit
// - each pin assertion lasts at least one full monitoring cycle
// - bit 3 clear: channel never drives the pin, pin only an input
// - bits 7:4 pick ramp temperature span, 2 to 80 degrees
// - span field resets to code 1100, 32 degrees
// - global lock makes channel registers read-only, writes ignored
//
// The AHB-Lite slave port was decided locally.
`include "frsc_cfg.svh"

module frsc_top #(
    parameter int CLK_HZ = `FRSC_NS_PER_S / `FRSC_CLK_PERIOD_NS
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire frsc_pkg::frsc_chan_meas_s [2:0] meas_i,
    input wire logic monitor_cycle_done_i,
    input wire logic [2:0][7:0] duty_i,
    output logic [2:0] fan_drive_o,
    output logic [2:0][3:0] ramp_temp_span_o,
    input wire logic overtemp_pin_i,
    output logic overtemp_pin_o,
    output logic overtemp_pin_oe_n_o,
    output logic processor_hot_o
);

    // ----------------------------------------------------------------
    // drive period step lengths
    // ----------------------------------------------------------------

    // cycles per duty step: the period is split into 256 steps
    function automatic logic [23:0] step_cycles(input logic [2:0] code);
        longint dhz;
        dhz = `FRSC_RATE0_DHZ;
        unique case (code)
            3'h0: dhz = `FRSC_RATE0_DHZ;
            3'h1: dhz = `FRSC_RATE1_DHZ;
            3'h2: dhz = `FRSC_RATE2_DHZ;
            3'h3: dhz = `FRSC_RATE3_DHZ;
            3'h4: dhz = `FRSC_RATE4_DHZ;
            3'h5: dhz = `FRSC_RATE5_DHZ;
            3'h6: dhz = `FRSC_RATE6_DHZ;
            3'h7: dhz = `FRSC_RATE7_DHZ;
        endcase
        step_cycles = 24'((longint'(CLK_HZ) * `FRSC_DHZ_PER_HZ) / (dhz * `FRSC_STEPS));
        if (step_cycles == 24'h000000) begin
            step_cycles = 24'h000001;
        end
    endfunction : step_cycles

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    frsc_pkg::frsc_state_s s_r;
    frsc_pkg::frsc_state_s s_nxt;

    logic addr_ok;
    logic [7:0] addr_idx;
    logic take;
    logic pin_low;

    // word index of the address phase; anything outside the low kilobyte is unmapped
    assign addr_idx = haddr_i[`FRSC_ADDR_IDX_LSB +: `FRSC_IDX_W];
    assign addr_ok = (haddr_i[31:10] == 22'h000000) && (haddr_i[1:0] == 2'h0);
    assign take = hsel_i && htrans_i[1] && hready_i;

    // pin is low if any channel asserts it or the far side pulls it
    assign pin_low = !s_r.pin_sync[1];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] wbyte;
        logic [2:0] hot_v;
        wbyte = hwdata_i[7:0];
        hot_v = 3'h0;
        s_nxt = s_r;

        // second flop of the pin synchroniser only reads the first
        s_nxt.pin_sync = {s_r.pin_sync[0], overtemp_pin_i};
        // own release delayed as far as the synchroniser, so our own low is not taken for
        // the far side's hot signal while it drains
        s_nxt.own_sync = {s_r.own_sync[0], overtemp_pin_oe_n_o};

        // data phase of a write: channel registers, then the lock
        if (s_r.dph_wr) begin
            unique case (s_r.dph_idx)
                `FRSC_IDX_REMOTE1: begin
                    if (!s_r.lock) begin
                        s_nxt.cfg[0] = wbyte;
                    end
                end
                `FRSC_IDX_LOCAL: begin
                    if (!s_r.lock) begin
                        s_nxt.cfg[1] = wbyte;
                    end
                end
                `FRSC_IDX_REMOTE2: begin
                    if (!s_r.lock) begin
                        s_nxt.cfg[2] = wbyte;
                    end
                end
                `FRSC_IDX_CTRL: begin
                    // lock can only be set; only a reset clears it
                    s_nxt.lock = s_r.lock | wbyte[`FRSC_CTRL_LOCK_BIT];
                end
                default: begin
                    s_nxt.lock = s_r.lock;
                end
            endcase
        end

        // per channel: drive period and over-temperature tracking
        for (int c = 0; c < 3; c++) begin
            // step divider; rate and duty are only picked up at the period wrap
            if (s_r.run[c].pre >= step_cycles(s_r.run[c].rate) - 24'h000001) begin
                s_nxt.run[c].pre = 24'h000000;
                s_nxt.run[c].step = s_r.run[c].step + 8'h01;
                if (s_r.run[c].step == 8'hFF) begin
                    s_nxt.run[c].rate = s_r.cfg[c].drive_rate_select;
                    s_nxt.run[c].duty = duty_i[c];
                end
            end else begin
                s_nxt.run[c].pre = s_r.run[c].pre + 24'h000001;
            end
            // high for the first duty steps of the period
            s_nxt.run[c].drive = (s_nxt.run[c].step < s_nxt.run[c].duty);

            // over-temperature hold and release
            if (!s_r.cfg[c].overtemp_pin_drive_enable) begin
                s_nxt.run[c].hot = 1'b0;
                s_nxt.run[c].mon_ends = 2'h0;
            end else if (!s_r.run[c].hot) begin
                if (meas_i[c].temp > meas_i[c].limit) begin
                    s_nxt.run[c].hot = 1'b1;
                    s_nxt.run[c].mon_ends = 2'h0;
                end
            end else begin
                // count monitoring-cycle ends, saturating at the minimum
                if (monitor_cycle_done_i && s_r.run[c].mon_ends != `FRSC_MIN_MON_ENDS) begin
                    s_nxt.run[c].mon_ends = s_r.run[c].mon_ends + 2'h1;
                end
                // release only when cool again and a full cycle has passed
                if (meas_i[c].temp <= meas_i[c].limit
                        && s_r.run[c].mon_ends == `FRSC_MIN_MON_ENDS) begin
                    s_nxt.run[c].hot = 1'b0;
                end
            end
            hot_v[c] = s_r.run[c].hot;
        end

        // address phase: latch the write, or fetch read data; channel and control reads see the updated state, status the current one
        s_nxt.dph_wr = 1'b0;
        if (take) begin
            s_nxt.dph_idx = addr_ok ? addr_idx : 8'h00;
            s_nxt.dph_wr = hwrite_i && addr_ok;
            if (!hwrite_i) begin
                s_nxt.rdata = 8'h00;
                if (addr_ok) begin
                    unique case (addr_idx)
                        `FRSC_IDX_REMOTE1: s_nxt.rdata = s_nxt.cfg[0];
                        `FRSC_IDX_LOCAL: s_nxt.rdata = s_nxt.cfg[1];
                        `FRSC_IDX_REMOTE2: s_nxt.rdata = s_nxt.cfg[2];
                        `FRSC_IDX_CTRL: s_nxt.rdata[`FRSC_CTRL_LOCK_BIT] = s_nxt.lock;
                        `FRSC_IDX_STATUS: begin
                            s_nxt.rdata[`FRSC_STAT_PIN_BIT] = |hot_v;
                            s_nxt.rdata[`FRSC_STAT_HOT_LSB +: 3] = hot_v;
                            s_nxt.rdata[`FRSC_STAT_IN_BIT] = pin_low;
                            s_nxt.rdata[`FRSC_STAT_LOCK_BIT] = s_r.lock;
                        end
                        default: s_nxt.rdata = 8'h00;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------

    // reset loads constants only; the pin synchroniser idles high (released)
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < 3; c++) begin
                s_r.cfg[c].ramp_temp_span <= `FRSC_SPAN_RESET;
                s_r.cfg[c].overtemp_pin_drive_enable <= 1'b0;
                s_r.cfg[c].drive_rate_select <= `FRSC_RATE_RESET;
                s_r.run[c].pre <= 24'h000000;
                s_r.run[c].step <= 8'h00;
                s_r.run[c].rate <= `FRSC_RATE_RESET;
                s_r.run[c].duty <= 8'h00;
                s_r.run[c].drive <= 1'b0;
                s_r.run[c].hot <= 1'b0;
                s_r.run[c].mon_ends <= 2'h0;
            end
            s_r.lock <= 1'b0;
            s_r.dph_wr <= 1'b0;
            s_r.dph_idx <= 8'h00;
            s_r.rdata <= 8'h00;
            s_r.pin_sync <= 2'h3;
            s_r.own_sync <= 2'h3;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // zero wait states: every transfer completes in its first data cycle
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = {24'h000000, s_r.rdata};

    // fan drive and span straight from flops
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            fan_drive_o[c] = s_r.run[c].drive;
            ramp_temp_span_o[c] = s_r.cfg[c].ramp_temp_span;
        end
    end

    // open drain: enable low means the pin is pulled low, never driven high
    assign overtemp_pin_o = 1'b0;
    assign overtemp_pin_oe_n_o = !(s_r.run[0].hot | s_r.run[1].hot | s_r.run[2].hot);

    // a low pin that no channel is driving is the far side's hot signal
    // masked until two clocks after our own release have flushed the synchroniser
    assign processor_hot_o = pin_low && overtemp_pin_oe_n_o && (&s_r.own_sync);

endmodule : frsc_top

// file: rtl/frsc_cfg.svh
// constants for the fan rate and span configuration block
`ifndef FRSC_CFG_SVH
`define FRSC_CFG_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define FRSC_CLK_PERIOD_NS 10
`define FRSC_NS_PER_S 1000000000

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define FRSC_IDX_REMOTE1 8'h5F
`define FRSC_IDX_LOCAL 8'h60
`define FRSC_IDX_REMOTE2 8'h61
`define FRSC_IDX_CTRL 8'h40
`define FRSC_IDX_STATUS 8'h41
`define FRSC_IDX_W 8
`define FRSC_ADDR_IDX_LSB 2

// ----------------------------------------------------------------
// channel register fields and reset values
// ----------------------------------------------------------------
`define FRSC_CFG_RESET 8'hC4
`define FRSC_RATE_RESET 3'h4
`define FRSC_SPAN_RESET 4'hC
`define FRSC_CTRL_LOCK_BIT 0
`define FRSC_STAT_PIN_BIT 0
`define FRSC_STAT_HOT_LSB 1
`define FRSC_STAT_IN_BIT 4
`define FRSC_STAT_LOCK_BIT 5

// ----------------------------------------------------------------
// drive rates in tenths of a hertz, code 0 to 7
// ----------------------------------------------------------------
`define FRSC_RATE0_DHZ 110
`define FRSC_RATE1_DHZ 147
`define FRSC_RATE2_DHZ 221
`define FRSC_RATE3_DHZ 294
`define FRSC_RATE4_DHZ 353
`define FRSC_RATE5_DHZ 441
`define FRSC_RATE6_DHZ 588
`define FRSC_RATE7_DHZ 882
`define FRSC_DHZ_PER_HZ 10
`define FRSC_STEPS 256

// monitoring-cycle ends to see before release: the first may close a partial cycle
`define FRSC_MIN_MON_ENDS 2'h2

`endif

// file: rtl/frsc_pkg.sv
// types of the fan rate and span configuration block
package frsc_pkg;

    // one channel register, laid out as software sees it
    typedef struct packed {
        logic [3:0] ramp_temp_span;
        logic overtemp_pin_drive_enable;
        logic [2:0] drive_rate_select;
    } frsc_chan_cfg_s;

    // measured temperature and its over-temperature limit
    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] limit;
    } frsc_chan_meas_s;

    // running state of one drive channel
    typedef struct packed {
        logic [23:0] pre;
        logic [7:0] step;
        logic [2:0] rate;
        logic [7:0] duty;
        logic drive;
        logic hot;
        logic [1:0] mon_ends;
    } frsc_chan_run_s;

    // whole state of the block
    typedef struct packed {
        frsc_chan_cfg_s [2:0] cfg;
        frsc_chan_run_s [2:0] run;
        logic lock;
        logic dph_wr;
        logic [7:0] dph_idx;
        logic [7:0] rdata;
        logic [1:0] pin_sync;
        logic [1:0] own_sync;
    } frsc_state_s;

endpackage : frsc_pkg

// file: test/frsc_top_asserts.sv
// port-level checks of the fan rate and span configuration block
module frsc_top_asserts (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire frsc_pkg::frsc_chan_meas_s [2:0] meas_i,
    input wire logic monitor_cycle_done_i,
    input wire logic [2:0][3:0] ramp_temp_span_o,
    input wire logic overtemp_pin_i,
    input wire logic overtemp_pin_oe_n_o,
    input wire logic processor_hot_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] idx_r;
    logic wr_dph_r;
    logic locked_r;
    logic [2:0] en_r;
    logic [1:0] ends_r;
    logic [2:0] over;
    logic hot;
    // ----------------------------------------------------------------
    // shadow of enable and lock, seen from bus traffic
    // ----------------------------------------------------------------
    assign over[0] = meas_i[0].temp > meas_i[0].limit;
    assign over[1] = meas_i[1].temp > meas_i[1].limit;
    assign over[2] = meas_i[2].temp > meas_i[2].limit;
    assign hot = |(en_r & over);
    // monitoring ends are only counted while the pin is pulled
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idx_r <= 8'h00;
            wr_dph_r <= 1'b0;
            locked_r <= 1'b0;
            en_r <= 3'h0;
            ends_r <= 2'h0;
        end else begin
            wr_dph_r <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
            if (hsel_i & htrans_i[1] & hready_i) idx_r <= haddr_i[9:2];
            if (wr_dph_r && idx_r == 8'h40 && hwdata_i[0]) locked_r <= 1'b1;
            for (int k = 0; k < 3; k++) begin
                if (wr_dph_r && !locked_r && idx_r == 8'(8'h5F + k)) en_r[k] <= hwdata_i[3];
            end
            if (overtemp_pin_oe_n_o) ends_r <= 2'h0;
            else if (monitor_cycle_done_i && ends_r != 2'h2) ends_r <= ends_r + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_hot_pulls_pin: assert property (hot |=> !overtemp_pin_oe_n_o)
        else $error("enabled channel over limit but pin not pulled");
    a_release_cool: assert property ($rose(overtemp_pin_oe_n_o) |-> !$past(hot))
        else $error("pin released while a channel is over limit");
    a_min_hold: assert property ($rose(overtemp_pin_oe_n_o) && $past(en_r, 2) == en_r
        |-> $past(ends_r) == 2'h2)
        else $error("pin released before a full monitoring cycle");
    a_pin_cause: assert property ($fell(overtemp_pin_oe_n_o) |-> $past(hot))
        else $error("pin pulled with no enabled channel over limit");
    a_input_only: assert property (processor_hot_o |-> overtemp_pin_oe_n_o && !$past(overtemp_pin_i, 2))
        else $error("processor hot flag without outside pull");
    a_span_write: assert property (!$stable(ramp_temp_span_o) |-> $past(wr_dph_r) && !$past(locked_r))
        else $error("span changed without an unlocked write");
    a_span_reset: assert property (!$past(rst_n_i) |-> ramp_temp_span_o == {3{4'hC}})
        else $error("span not at its power-on code after reset");
    a_lock_hold: assert property (locked_r |=> $stable(ramp_temp_span_o))
        else $error("span changed after lock");
    c_pin_pull: cover property ($fell(overtemp_pin_oe_n_o));
    c_proc_hot: cover property (processor_hot_o);
    c_locked_write: cover property (locked_r && wr_dph_r);
endmodule : frsc_top_asserts

// file: test/frsc_fan_model.sv
// far side: drive period meter and throttle line with its pull-up
module frsc_fan_model (
    input wire logic core_clk_i,
    input wire logic [2:0] fan_drive_i,
    input wire logic pin_oe_n_i,
    input wire logic pin_d_i,
    input wire logic throttle_i,
    output logic pin_o,
    output logic [2:0][15:0] period_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0][15:0] cnt_r = '0;
    logic [2:0] last_r = 3'h0;
    // pulled-up line: the block's driven level while enabled, low when the throttle side pulls
    assign pin_o = (pin_oe_n_i || pin_d_i) && !throttle_i;
    // clocks between rising edges of each drive output
    always @(posedge core_clk_i) begin
        last_r <= fan_drive_i;
        for (int k = 0; k < 3; k++) begin
            cnt_r[k] <= cnt_r[k] + 16'h1;
            if (fan_drive_i[k] && !last_r[k]) begin
                period_o[k] <= cnt_r[k] + 16'h1;
                cnt_r[k] <= 16'h0;
            end
        end
    end
endmodule : frsc_fan_model

// file: test/testbench.sv
// self-checking bench of the fan rate and span configuration block
`include "frsc_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CLK_HZ = 51200; // short steps, yet every rate code has a period of its own
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic [31:0] rd;
    logic hreadyout_o;
    logic hresp_o;
    frsc_pkg::frsc_chan_meas_s [2:0] meas_i = '0;
    logic monitor_cycle_done_i = 1'b0;
    logic [2:0][7:0] duty_i = {3{8'h80}};
    logic [2:0] fan_drive_o;
    logic [2:0][3:0] ramp_temp_span_o;
    logic overtemp_pin_i;
    logic overtemp_pin_oe_n_o;
    logic processor_hot_o;
    logic overtemp_pin_o;
    logic thr = 1'b0;
    logic [2:0][15:0] period;
    logic [31:0] seed = 32'h3E3D;
    int n_mismatch = 0;
    int num_checks = 0;
    frsc_top #(.CLK_HZ(CLK_HZ)) u_frsc_top (.core_clk_i, .rst_n_i, .hsel_i, .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
        .hreadyout_o, .hresp_o, .meas_i, .monitor_cycle_done_i, .duty_i, .fan_drive_o,
        .ramp_temp_span_o, .overtemp_pin_i, .overtemp_pin_o, .overtemp_pin_oe_n_o,
        .processor_hot_o);
    frsc_fan_model u_frsc_fan_model (.core_clk_i, .fan_drive_i(fan_drive_o),
        .pin_oe_n_i(overtemp_pin_oe_n_o), .pin_d_i(overtemp_pin_o), .throttle_i(thr),
        .pin_o(overtemp_pin_i),
        .period_o(period));
    always #5 core_clk_i = ~core_clk_i;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] adr(input int k);
        return {22'h0, 8'(`FRSC_IDX_REMOTE1 + k), 2'h0};
    endfunction : adr
    // one drive period in clocks: 256 steps of the truncated step length
    function automatic logic [15:0] exp_period(input logic [2:0] c);
        int dhz [8] = '{`FRSC_RATE0_DHZ, `FRSC_RATE1_DHZ, `FRSC_RATE2_DHZ, `FRSC_RATE3_DHZ,
            `FRSC_RATE4_DHZ, `FRSC_RATE5_DHZ, `FRSC_RATE6_DHZ, `FRSC_RATE7_DHZ};
        return 16'(CLK_HZ * 10 / (dhz[c] * 256) * 256);
    endfunction : exp_period
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, e, s);
        end
    endtask : chk
    // one single AHB transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        chk("hresp", 32'h0, {31'h0, hresp_o});
    endtask : xfer
    task automatic pulse(input int gap);
        monitor_cycle_done_i <= 1'b1;
        @(posedge core_clk_i);
        monitor_cycle_done_i <= 1'b0;
        repeat (gap) @(posedge core_clk_i);
    endtask : pulse
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // a hang is cut well beyond the roughly 52k clocks the tests need
    initial begin
        repeat (90000) @(posedge core_clk_i);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        int k;
        logic [31:0] r;
        logic [7:0] v;
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        for (int c = 0; c < 3; c++) begin
            xfer(1'b0, adr(c), 32'h0);
            chk("cfg reset", 32'hC4, rd);
        end
        chk("span reset", {20'h0, ramp_temp_span_o}, {20'h0, {3{4'hC}}});
        xfer(1'b0, 32'h3FC, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test reset values done");
        // every rate code on a rotating channel, random span on top
        for (int c = 0; c < 8; c++) begin
            r = rnd();
            v = {r[7:4], 1'b0, 3'(c)};
            xfer(1'b1, adr(c % 3), {24'h0, v});
            xfer(1'b0, adr(c % 3), 32'h0);
            chk("cfg readback", {24'h0, v}, rd);
            chk("span out", {28'h0, v[7:4]}, {28'h0, ramp_temp_span_o[c % 3]});
            // old period runs out at most one slowest period later, then one new period
            repeat (exp_period(3'h0) + exp_period(3'(c)) + 16) @(posedge core_clk_i);
            chk("drive period", {16'h0, exp_period(3'(c))}, {16'h0, period[c % 3]});
        end
        $display("test drive rates done");
        // enabled channel over its limit, held and released on the boundary
        k = int'(rnd() % 32'h3);
        r = rnd();
        xfer(1'b1, adr(k), 32'hC8);
        meas_i[k].limit <= {1'b0, r[6:0]};
        meas_i[k].temp <= {1'b0, r[6:0]} + 8'h1;
        repeat (2) @(posedge core_clk_i);
        chk("pin pulled", 32'h0, {31'h0, overtemp_pin_oe_n_o});
        pulse(3);
        pulse(3);
        chk("pin held hot", 32'h0, {31'h0, overtemp_pin_oe_n_o});
        xfer(1'b0, {22'h0, `FRSC_IDX_STATUS, 2'h0}, 32'h0);
        chk("status hot", (32'h1 << `FRSC_STAT_PIN_BIT) | (32'h1 << (`FRSC_STAT_HOT_LSB + k))
            | (32'h1 << `FRSC_STAT_IN_BIT), rd);
        meas_i[k].temp <= {1'b0, r[6:0]};
        repeat (3) @(posedge core_clk_i);
        chk("pin released", 32'h1, {31'h0, overtemp_pin_oe_n_o});
        meas_i[k].temp <= {1'b0, r[6:0]} + 8'h1;
        @(posedge core_clk_i);
        meas_i[k].temp <= {1'b0, r[6:0]};
        repeat (4) @(posedge core_clk_i);
        chk("pin minimum", 32'h0, {31'h0, overtemp_pin_oe_n_o});
        pulse(3);
        chk("pin one end", 32'h0, {31'h0, overtemp_pin_oe_n_o});
        pulse(3);
        chk("pin two ends", 32'h1, {31'h0, overtemp_pin_oe_n_o});
        $display("test pin drive done");
        // enable clear: over limit stays off the pin, outside pull is seen
        xfer(1'b1, adr(k), 32'hC0);
        meas_i[k].temp <= {1'b0, r[6:0]} + 8'h1;
        thr <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        chk("pin input only", 32'h1, {31'h0, overtemp_pin_oe_n_o});
        chk("processor hot", 32'h1, {31'h0, processor_hot_o});
        thr <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        chk("processor cool", 32'h0, {31'h0, processor_hot_o});
        $display("test pin input done");
        // after lock, a write leaves the channel as it was
        xfer(1'b1, 32'h100, 32'h1);
        xfer(1'b1, adr(k), 32'h35);
        xfer(1'b0, adr(k), 32'h0);
        chk("locked cfg", 32'hC0, rd);
        chk("locked span", 32'hC, {28'h0, ramp_temp_span_o[k]});
        xfer(1'b0, {22'h0, `FRSC_IDX_CTRL, 2'h0}, 32'h0);
        chk("lock state", 32'h1, rd);
        $display("test lock done");
        print_verdict();
    end
endmodule : testbench
bind frsc_top frsc_top_asserts u_frsc_top_asserts (.core_clk_i, .rst_n_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .meas_i, .monitor_cycle_done_i,
    .ramp_temp_span_o, .overtemp_pin_i, .overtemp_pin_oe_n_o, .processor_hot_o);
